// *** rtl/tcc_timer_capture.sv ***
// 16-bit timer counter with shared high-byte register and input capture
`timescale 1ns/100ps
`default_nettype none
module tcc_timer_capture (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [1:0] i_cpu_select,
  input wire logic i_cpu_read,
  input wire logic i_cpu_write,
  input wire logic [7:0] i_cpu_wdata,
  output logic [7:0] o_cpu_rdata,
  input wire logic [2:0] i_clock_select_field,
  input wire logic [1:0] i_wave_mode_low,
  input wire logic [1:0] i_wave_mode_high,
  input wire logic i_noise_cancel_enable,
  input wire logic i_capture_rising_edge,
  input wire logic i_comparator_capture_select,
  input wire logic i_capture_irq_enable,
  input wire logic i_overflow_irq_enable,
  input wire logic i_capture_flag_clear,
  input wire logic i_capture_irq_ack,
  input wire logic i_overflow_flag_clear,
  input wire logic i_overflow_irq_ack,
  input wire logic [3:0] i_prescale_tick,
  input wire logic i_external_count_pin,
  input wire logic i_capture_pin,
  input wire logic i_comparator_output,
  input wire logic [15:0] i_compare_top,
  output logic [15:0] o_count_value,
  output logic [15:0] o_capture_value,
  output logic o_capture_flag,
  output logic o_overflow_flag,
  output logic o_capture_irq,
  output logic o_overflow_irq
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] temp;
    logic [15:0] capture;
    logic down;
    logic cap_flag;
    logic ovf_flag;
    logic cap_irq;
    logic ovf_irq;
    logic [7:0] rdata;
  } tcc_top_s;

  localparam tcc_top_s TOP_RESET = '{
    temp: tcc_pkg::TEMP_RESET,
    capture: tcc_pkg::CAPTURE_RESET,
    down: 1'b0,
    cap_flag: 1'b0,
    ovf_flag: 1'b0,
    cap_irq: 1'b0,
    ovf_irq: 1'b0,
    rdata: tcc_pkg::RDATA_RESET
  };

  tcc_top_s top_reg;
  tcc_top_s top_next;

  tcc_core_if core_bus ();

  logic [3:0] mode;
  logic cap_top;
  logic ext_edge;
  logic cap_edge;
  logic tick;
  logic at_top;
  logic [15:0] top_val;
  logic [1:0] tap;
  tcc_pkg::tcc_class_e cls;

  // mode split across both control registers
  assign mode = {i_wave_mode_high, i_wave_mode_low};
  // trigger idle when capture is the top
  assign cap_top = (tcc_pkg::tcc_top_kind(mode) == tcc_pkg::TOPK_CAP);

  // ==========================================================
  // inputs from pins
  tcc_trigger u_ext_pin (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_raw({1'b0, i_external_count_pin}),
    .i_source_select(1'b0),
    .i_filter_enable(1'b0),
    .i_rising(i_clock_select_field == tcc_pkg::CS_EXT_RISE),
    .i_enable(1'b1),
    .o_edge(ext_edge)
  );

  // same sync and edge path as the count pin
  // the pin level is watched, whoever drives it
  tcc_trigger u_capture_trig (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_raw({i_comparator_output, i_capture_pin}),
    .i_source_select(i_comparator_capture_select),
    .i_filter_enable(i_noise_cancel_enable),
    .i_rising(i_capture_rising_edge),
    .i_enable(!cap_top),
    .o_edge(cap_edge)
  );

  tcc_counter_core u_core (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .bus(core_bus)
  );

  // ==========================================================
  // next state
  always_comb begin
    top_next = top_reg;
    cls = tcc_pkg::tcc_mode_class(mode);
    tap = 2'(i_clock_select_field - tcc_pkg::CS_PRE_FIRST);
    case (i_clock_select_field)
      tcc_pkg::CS_NONE: tick = 1'b0;
      tcc_pkg::CS_SYS: tick = 1'b1;
      tcc_pkg::CS_EXT_FALL: tick = ext_edge;
      tcc_pkg::CS_EXT_RISE: tick = ext_edge;
      default: tick = i_prescale_tick[tap];
    endcase
    case (tcc_pkg::tcc_top_kind(mode))
      tcc_pkg::TOPK_8: top_val = tcc_pkg::TOP_8BIT;
      tcc_pkg::TOPK_9: top_val = tcc_pkg::TOP_9BIT;
      tcc_pkg::TOPK_10: top_val = tcc_pkg::TOP_10BIT;
      tcc_pkg::TOPK_CMP: top_val = i_compare_top;
      tcc_pkg::TOPK_CAP: top_val = top_reg.capture;
      default: top_val = tcc_pkg::CNT_MAX;
    endcase
    at_top = (core_bus.value == top_val);
    core_bus.step = 1'b0;
    core_bus.up = 1'b1;
    core_bus.clear = 1'b0;
    core_bus.load = 1'b0;
    core_bus.load_value = {top_reg.temp, i_cpu_wdata};

    // ----------------------------------------------------------
    // flag clears first so a same-cycle set wins
    // ack or write-one clears
    if (i_capture_flag_clear || i_capture_irq_ack) begin
      top_next.cap_flag = 1'b0;
    end
    if (i_overflow_flag_clear || i_overflow_irq_ack) begin
      top_next.ovf_flag = 1'b0;
    end

    // ----------------------------------------------------------
    // counting sequence per tick
    if (cls != tcc_pkg::CLS_PHASE) begin
      top_next.down = 1'b0;
    end
    if (tick) begin
      if (cls == tcc_pkg::CLS_PHASE) begin
        core_bus.step = 1'b1;
        if (!top_reg.down && at_top) begin
          top_next.down = 1'b1;
          core_bus.up = 1'b0;
        end else if (top_reg.down && core_bus.at_zero) begin
          top_next.down = 1'b0;
          top_next.ovf_flag = 1'b1;
        end else begin
          core_bus.up = !top_reg.down;
        end
      end else begin
        // clear at top, else step up
        if (at_top) begin
          core_bus.clear = 1'b1;
        end else begin
          core_bus.step = 1'b1;
        end
        // fast overflows at top, others at max
        if (cls == tcc_pkg::CLS_FAST ? at_top : core_bus.at_max) begin
          top_next.ovf_flag = 1'b1;
        end
      end
    end

    // ----------------------------------------------------------
    // cpu byte access; a write in the same cycle as a read wins on temp
    if (i_cpu_read) begin
      case (tcc_pkg::tcc_sel_e'(i_cpu_select))
        // low read latches high into temp
        tcc_pkg::SEL_CNT_LO: begin
          top_next.rdata = core_bus.value[7:0];
          top_next.temp = core_bus.value[15:8];
        end
        tcc_pkg::SEL_CAP_LO: begin
          top_next.rdata = top_reg.capture[7:0];
          top_next.temp = top_reg.capture[15:8];
        end
        default: top_next.rdata = top_reg.temp;
      endcase
    end
    if (i_cpu_write) begin
      case (tcc_pkg::tcc_sel_e'(i_cpu_select))
        // load works whether or not ticks run
        // load has priority in the core
        tcc_pkg::SEL_CNT_LO: core_bus.load = 1'b1;
        // only while capture sets the top
        tcc_pkg::SEL_CAP_LO: begin
          if (cap_top) begin
            top_next.capture = {top_reg.temp, i_cpu_wdata};
          end
        end
        default: top_next.temp = i_cpu_wdata;
      endcase
    end

    // ----------------------------------------------------------
    // copy the full count on an edge
    // a source switch edge lands here too
    if (cap_edge) begin
      top_next.capture = core_bus.value;
      top_next.cap_flag = 1'b1;
    end
    top_next.cap_irq = top_next.cap_flag & i_capture_irq_enable;
    top_next.ovf_irq = top_next.ovf_flag & i_overflow_irq_enable;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      top_reg <= TOP_RESET;
    end else begin
      top_reg <= top_next;
    end
  end

  // ==========================================================
  // outputs
  assign o_cpu_rdata = top_reg.rdata;
  assign o_count_value = core_bus.value;
  assign o_capture_value = top_reg.capture;
  assign o_capture_flag = top_reg.cap_flag;
  assign o_overflow_flag = top_reg.ovf_flag;
  assign o_capture_irq = top_reg.cap_irq;
  assign o_overflow_irq = top_reg.ovf_irq;
endmodule
`default_nettype wire

// *** shared/tcc_pkg.sv ***
// constants, types and mode decoding for the timer counter with input capture
package tcc_pkg;

  // ==========================================================
  // widths and fixed values
  localparam int CNT_W = 16;
  localparam int BYTE_W = 8;
  localparam int PRESC_TAPS = 4;
  localparam int SRC_W = 2;
  localparam int FILT_SAMPLES = 4;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam logic [15:0] CAPTURE_RESET = 16'h0000;
  localparam logic [7:0] TEMP_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // ==========================================================
  // clock select codes
  localparam logic [2:0] CS_NONE = 3'h0;
  localparam logic [2:0] CS_SYS = 3'h1;
  localparam logic [2:0] CS_PRE_FIRST = 3'h2;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // ==========================================================
  // cpu byte locations, counter classes, top sources
  typedef enum logic [1:0] {
    SEL_CNT_LO = 2'b00,
    SEL_CNT_HI = 2'b01,
    SEL_CAP_LO = 2'b10,
    SEL_CAP_HI = 2'b11
  } tcc_sel_e;

  typedef enum logic [1:0] {
    CLS_NORMAL = 2'b00,
    CLS_CTC = 2'b01,
    CLS_FAST = 2'b10,
    CLS_PHASE = 2'b11
  } tcc_class_e;

  typedef enum logic [2:0] {
    TOPK_MAX = 3'b000,
    TOPK_8 = 3'b001,
    TOPK_9 = 3'b010,
    TOPK_10 = 3'b011,
    TOPK_CMP = 3'b100,
    TOPK_CAP = 3'b101
  } tcc_topk_e;

  function automatic tcc_class_e tcc_mode_class(input logic [3:0] mode);
    case (mode)
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb: tcc_mode_class = CLS_PHASE;
      4'h4, 4'hc: tcc_mode_class = CLS_CTC;
      4'h5, 4'h6, 4'h7, 4'he, 4'hf: tcc_mode_class = CLS_FAST;
      default: tcc_mode_class = CLS_NORMAL;
    endcase
  endfunction

  function automatic tcc_topk_e tcc_top_kind(input logic [3:0] mode);
    case (mode)
      4'h1, 4'h5: tcc_top_kind = TOPK_8;
      4'h2, 4'h6: tcc_top_kind = TOPK_9;
      4'h3, 4'h7: tcc_top_kind = TOPK_10;
      4'h4, 4'h9, 4'hb, 4'hf: tcc_top_kind = TOPK_CMP;
      4'h8, 4'ha, 4'hc, 4'he: tcc_top_kind = TOPK_CAP;
      default: tcc_top_kind = TOPK_MAX;
    endcase
  endfunction

endpackage

// *** shared/tcc_core_if.sv ***
// link between the timer control logic and the counter core
`timescale 1ns/100ps
`default_nettype none
interface tcc_core_if;
  logic step;
  logic up;
  logic clear;
  logic load;
  logic [tcc_pkg::CNT_W-1:0] load_value;
  logic [tcc_pkg::CNT_W-1:0] value;
  logic at_max;
  logic at_zero;
  modport ctrl (output step, up, clear, load, load_value, input value, at_max, at_zero);
  modport core (input step, up, clear, load, load_value, output value, at_max, at_zero);
endinterface
`default_nettype wire

// *** rtl/tcc_counter_core.sv ***
// 16-bit up/down counter with load, clear and end indications
`timescale 1ns/100ps
`default_nettype none
module tcc_counter_core (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  tcc_core_if.core bus
);
  typedef struct packed {
    logic [tcc_pkg::CNT_W-1:0] value;
  } tcc_core_s;

  tcc_core_s core_reg;
  tcc_core_s core_next;

  always_comb begin
    core_next = core_reg;
    if (bus.load) begin
      core_next.value = bus.load_value;
    end else if (bus.clear) begin
      core_next.value = tcc_pkg::CNT_ZERO;
    end else if (bus.step) begin
      core_next.value = bus.up ? 16'(core_reg.value + 16'h0001)
                               : 16'(core_reg.value - 16'h0001);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      core_reg <= '{value: tcc_pkg::CNT_ZERO};
    end else begin
      core_reg <= core_next;
    end
  end

  assign bus.value = core_reg.value;
  assign bus.at_max = (core_reg.value == tcc_pkg::CNT_MAX);
  assign bus.at_zero = (core_reg.value == tcc_pkg::CNT_ZERO);
endmodule
`default_nettype wire

// *** rtl/tcc_trigger.sv ***
// pin synchroniser, source mux, four-sample filter and edge detector
`timescale 1ns/100ps
`default_nettype none
module tcc_trigger (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [tcc_pkg::SRC_W-1:0] i_raw,
  input wire logic i_source_select,
  input wire logic i_filter_enable,
  input wire logic i_rising,
  input wire logic i_enable,
  output logic o_edge
);
  typedef struct packed {
    logic [tcc_pkg::SRC_W-1:0] meta;
    logic [tcc_pkg::SRC_W-1:0] sync;
    logic [tcc_pkg::FILT_SAMPLES-1:0] hist;
    logic filt;
    logic prev;
    logic edge_hit;
  } tcc_trig_s;

  tcc_trig_s trig_reg;
  tcc_trig_s trig_next;

  always_comb begin
    logic src;
    logic sample;
    src = 1'b0;
    sample = 1'b0;
    trig_next = trig_reg;
    trig_next.meta = i_raw;
    trig_next.sync = trig_reg.meta;
    src = trig_reg.sync[i_source_select];
    trig_next.hist = {trig_reg.hist[tcc_pkg::FILT_SAMPLES-2:0], src};
    if (&trig_next.hist) begin
      trig_next.filt = 1'b1;
    end else if (~|trig_next.hist) begin
      trig_next.filt = 1'b0;
    end
    sample = i_filter_enable ? trig_reg.filt : src;
    trig_next.prev = sample;
    trig_next.edge_hit = i_enable & (i_rising ? (sample & ~trig_reg.prev)
                                              : (~sample & trig_reg.prev));
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      trig_reg <= '0;
    end else begin
      trig_reg <= trig_next;
    end
  end

  assign o_edge = trig_reg.edge_hit;
endmodule
`default_nettype wire

// *** test/tcc_timer_capture_properties.sv ***
// port-level checks for the timer counter with input capture
`timescale 1ns/100ps
`default_nettype none
module tcc_timer_capture_properties (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [1:0] i_cpu_select,
  input wire logic i_cpu_read,
  input wire logic i_cpu_write,
  input wire logic [7:0] i_cpu_wdata,
  input wire logic [7:0] o_cpu_rdata,
  input wire logic [2:0] i_clock_select_field,
  input wire logic [1:0] i_wave_mode_low,
  input wire logic [1:0] i_wave_mode_high,
  input wire logic i_capture_irq_enable,
  input wire logic i_capture_flag_clear,
  input wire logic i_capture_irq_ack,
  input wire logic [15:0] o_count_value,
  input wire logic [15:0] o_capture_value,
  input wire logic o_capture_flag,
  input wire logic o_overflow_flag,
  input wire logic o_capture_irq
);
  // ==========================================
  // shadow of the shared upper byte
  logic [7:0] temp_reg;
  logic [7:0] temp_next;
  logic [3:0] mode;
  logic run_up;
  assign mode = {i_wave_mode_high, i_wave_mode_low};
  assign run_up = i_clock_select_field == 3'h1 && mode == 4'h0 && !i_cpu_write;
  // write placed last: it wins over a read in the same cycle
  always_comb begin
    temp_next = temp_reg;
    if (i_cpu_read && i_cpu_select == 2'h0)
      temp_next = o_count_value[15:8];
    if (i_cpu_read && i_cpu_select == 2'h2)
      temp_next = o_capture_value[15:8];
    if (i_cpu_write && i_cpu_select[0])
      temp_next = i_cpu_wdata;
  end
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn)
      temp_reg <= 8'h00;
    else
      temp_reg <= temp_next;
  end
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);
  // ==========================================
  // properties
  stop_holds_a:
    assert property (i_clock_select_field == 3'h0 && !i_cpu_write |=> $stable(o_count_value))
    else $error("count moved with no clock source");
  count_up_a:
    assert property (run_up |=> o_count_value == $past(o_count_value) + 16'h1)
    else $error("count did not step by one");
  write_low_a:
    assert property (i_cpu_write && i_cpu_select == 2'h0 |=>
      o_count_value == {$past(temp_reg), $past(i_cpu_wdata)})
    else $error("count write lost");
  read_low_a:
    assert property (i_cpu_read && i_cpu_select == 2'h0 |=>
      o_cpu_rdata == $past(o_count_value[7:0]))
    else $error("count low read wrong");
  read_high_a:
    assert property (i_cpu_read && i_cpu_select[0] |=> o_cpu_rdata == $past(temp_reg))
    else $error("upper read not from temp");
  ovf_set_a:
    assert property (run_up && o_count_value == 16'hffff |=> o_overflow_flag)
    else $error("overflow flag missing");
  cap_copy_a:
    assert property ($rose(o_capture_flag) |-> o_capture_value == $past(o_count_value))
    else $error("capture value wrong");
  cap_flag_a:
    assert property ($changed(o_capture_value) && !$past(i_cpu_write) |-> o_capture_flag)
    else $error("capture without flag");
  irq_follow_a:
    assert property (o_capture_irq == (o_capture_flag && $past(i_capture_irq_enable)))
    else $error("capture irq wrong");
  flag_clear_a:
    assert property (i_capture_flag_clear || i_capture_irq_ack |=>
      !o_capture_flag || $changed(o_capture_value))
    else $error("capture flag not cleared");
  top_gate_a:
    assert property ((i_wave_mode_high[1] && !i_wave_mode_low[0])[*3] |=> !$rose(o_capture_flag))
    else $error("capture while capture is top");
  cover property ($rose(o_capture_flag));
  cover property ($rose(o_overflow_flag));
  cover property (i_cpu_read && i_cpu_select == 2'h3);
endmodule
`default_nettype wire

// *** test/tcc_cpu_model.sv ***
// cpu side model: byte accesses to the timer's 8-bit locations
`timescale 1ns/100ps
`default_nettype none
module tcc_cpu_model (
  input wire logic i_clk_sys,
  input wire logic [7:0] i_rdata,
  output logic [1:0] o_select,
  output logic o_read,
  output logic o_write,
  output logic [7:0] o_wdata
);
  // ==========================================
  // byte cycles, one request per wr or rd call; wr16 and rd16 make two
  initial begin
    o_select = 2'h0;
    o_read = 1'b0;
    o_write = 1'b0;
    o_wdata = 8'h00;
  end
  task automatic wr(input logic [1:0] sel, input logic [7:0] data);
    @(posedge i_clk_sys);
    o_select <= sel;
    o_wdata <= data;
    o_write <= 1'b1;
    @(posedge i_clk_sys);
    o_write <= 1'b0;
    // released bus shows no stale data
    o_wdata <= ~data;
  endtask
  task automatic rd(input logic [1:0] sel, output logic [7:0] data);
    @(posedge i_clk_sys);
    o_select <= sel;
    o_read <= 1'b1;
    @(posedge i_clk_sys);
    o_read <= 1'b0;
    #1;
    data = i_rdata;
  endtask
  task automatic wr16(input logic [1:0] lo_sel, input logic [15:0] v);
    wr(lo_sel | 2'h1, v[15:8]);
    wr(lo_sel, v[7:0]);
  endtask
  task automatic rd16(input logic [1:0] lo_sel, output logic [15:0] v);
    rd(lo_sel, v[7:0]);
    rd(lo_sel | 2'h1, v[15:8]);
  endtask
endmodule
`default_nettype wire

// *** test/tcc_timer_capture_test.sv ***
// self-checking bench for the timer counter with input capture
`timescale 1ns/100ps
`default_nettype none
module tcc_timer_capture_test;
  logic i_clk_sys, i_resetn, i_noise_cancel_enable, i_capture_rising_edge;
  logic i_comparator_capture_select, i_capture_irq_enable, i_overflow_irq_enable;
  logic i_capture_flag_clear, i_capture_irq_ack, i_capture_pin, i_comparator_output;
  logic i_external_count_pin;
  logic [2:0] i_clock_select_field;
  logic [1:0] i_wave_mode_low, i_wave_mode_high, i_cpu_select;
  logic [3:0] i_prescale_tick;
  logic i_cpu_read, i_cpu_write, o_capture_flag, o_overflow_flag, o_capture_irq, o_overflow_irq;
  logic [7:0] i_cpu_wdata, o_cpu_rdata;
  logic [15:0] o_count_value, o_capture_value, v;
  int n_fail = 0;
  int comparisons = 0;
  tcc_cpu_model cpu (.i_clk_sys, .i_rdata(o_cpu_rdata), .o_select(i_cpu_select),
    .o_read(i_cpu_read), .o_write(i_cpu_write), .o_wdata(i_cpu_wdata));
  tcc_timer_capture dut (.i_clk_sys, .i_resetn, .i_cpu_select, .i_cpu_read, .i_cpu_write,
    .i_cpu_wdata, .o_cpu_rdata, .i_clock_select_field, .i_wave_mode_low, .i_wave_mode_high,
    .i_noise_cancel_enable, .i_capture_rising_edge, .i_comparator_capture_select,
    .i_capture_irq_enable, .i_overflow_irq_enable, .i_capture_flag_clear,
    .i_capture_irq_ack, .i_overflow_flag_clear(1'b0), .i_overflow_irq_ack(1'b0),
    .i_prescale_tick, .i_external_count_pin, .i_capture_pin, .i_comparator_output,
    .i_compare_top(16'h0005), .o_count_value, .o_capture_value, .o_capture_flag,
    .o_overflow_flag, .o_capture_irq, .o_overflow_irq);
  always #10 i_clk_sys = ~i_clk_sys;
  // ==========================================
  // helpers
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic trig(input logic cmp, input logic lvl, input int n);
    @(posedge i_clk_sys);
    if (cmp)
      i_comparator_output <= lvl;
    else
      i_capture_pin <= lvl;
    cyc(n);
  endtask
  task automatic clr(input logic by_ack);
    @(posedge i_clk_sys);
    i_capture_irq_ack <= by_ack;
    i_capture_flag_clear <= !by_ack;
    @(posedge i_clk_sys);
    i_capture_irq_ack <= 1'b0;
    i_capture_flag_clear <= 1'b0;
    cyc(0);
  endtask
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========================================
  // tests
  initial begin
    i_clk_sys = 1'b0;
    i_resetn = 1'b0;
    {i_noise_cancel_enable, i_comparator_capture_select, i_capture_flag_clear} = 3'h0;
    {i_capture_irq_ack, i_capture_pin, i_comparator_output, i_external_count_pin} = 4'h0;
    {i_capture_rising_edge, i_capture_irq_enable, i_overflow_irq_enable} = 3'h7;
    {i_clock_select_field, i_wave_mode_high, i_wave_mode_low, i_prescale_tick} = 11'h000;
    repeat (3) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    cyc(1);
    check({4'h0, o_capture_flag, o_overflow_flag, o_capture_irq, o_overflow_irq, o_cpu_rdata},
      16'h0);
    check(o_count_value | o_capture_value, 16'h0000);
    cpu.wr16(2'h0, 16'h01ff);
    cpu.wr16(2'h2, 16'h5555);
    cyc(4);
    check(o_count_value, 16'h01ff);
    check(o_capture_value, 16'h0000);
    cpu.rd16(2'h0, v);
    check(v, 16'h01ff);
    $display("test stopped access done");
    for (int k = 0; k < 4; k++) begin
      cpu.wr16(2'h0, 16'h0000);
      @(posedge i_clk_sys);
      i_clock_select_field <= 3'(k + 2);
      i_prescale_tick <= ~(4'h1 << k);
      @(posedge i_clk_sys);
      i_prescale_tick <= 4'h1 << k;
      @(posedge i_clk_sys);
      i_prescale_tick <= 4'h0;
      i_clock_select_field <= 3'h0;
      cyc(1);
      check(o_count_value, 16'h0001);
    end
    cpu.wr(2'h1, 8'hff);
    @(posedge i_clk_sys);
    i_clock_select_field <= 3'h1;
    cpu.wr(2'h0, 8'hfd);
    cyc(0);
    check(o_count_value, 16'hfffd);
    cyc(3);
    check(o_count_value, 16'h0000);
    check(o_overflow_flag, 16'h1);
    cyc(1);
    check(o_overflow_irq, 16'h1);
    @(posedge i_clk_sys);
    i_clock_select_field <= 3'h0;
    i_wave_mode_low <= 2'h1;
    cpu.wr16(2'h0, 16'h00fe);
    @(posedge i_clk_sys);
    i_clock_select_field <= 3'h1;
    repeat (3) @(posedge i_clk_sys);
    i_clock_select_field <= 3'h0;
    i_wave_mode_low <= 2'h0;
    cyc(0);
    check(o_count_value, 16'h00fd);
    cpu.wr16(2'h0, 16'h0000);
    @(posedge i_clk_sys);
    i_clock_select_field <= 3'h7;
    i_external_count_pin <= 1'b1;
    cyc(6);
    check(o_count_value, 16'h0001);
    @(posedge i_clk_sys);
    i_clock_select_field <= 3'h6;
    i_external_count_pin <= 1'b0;
    cyc(6);
    check(o_count_value, 16'h0002);
    cpu.wr16(2'h0, 16'h0003);
    // fast mode with the compare value as top: 3, 4, 5, 0, 1
    @(posedge i_clk_sys);
    {i_wave_mode_high, i_wave_mode_low, i_clock_select_field} <= 7'h79;
    repeat (4) @(posedge i_clk_sys);
    {i_wave_mode_high, i_wave_mode_low, i_clock_select_field} <= 7'h00;
    cyc(0);
    check(o_count_value, 16'h0001);
    $display("test counting done");
    cpu.wr16(2'h0, 16'h1234);
    trig(1'b0, 1'b1, 3);
    check(o_capture_flag, 16'h0);
    cyc(1);
    check(o_capture_value, 16'h1234);
    check(o_capture_flag, 16'h1);
    cyc(1);
    check(o_capture_irq, 16'h1);
    cpu.rd16(2'h2, v);
    check(v, 16'h1234);
    clr(1'b1);
    check(o_capture_flag, 16'h0);
    trig(1'b0, 1'b0, 6);
    check(o_capture_flag, 16'h0);
    @(posedge i_clk_sys);
    i_capture_rising_edge <= 1'b0;
    cpu.wr16(2'h0, 16'h0055);
    trig(1'b0, 1'b1, 6);
    check(o_capture_flag, 16'h0);
    trig(1'b0, 1'b0, 6);
    check(o_capture_value, 16'h0055);
    clr(1'b0);
    check(o_capture_flag, 16'h0);
    $display("test capture done");
    @(posedge i_clk_sys);
    i_noise_cancel_enable <= 1'b1;
    i_capture_rising_edge <= 1'b1;
    cpu.wr16(2'h0, 16'h0aa0);
    // three equal samples only: the filter must reject this pulse
    trig(1'b0, 1'b1, 2);
    trig(1'b0, 1'b0, 12);
    check(o_capture_flag, 16'h0);
    trig(1'b0, 1'b1, 7);
    check(o_capture_flag, 16'h0);
    cyc(1);
    check(o_capture_value, 16'h0aa0);
    @(posedge i_clk_sys);
    i_noise_cancel_enable <= 1'b0;
    i_comparator_capture_select <= 1'b1;
    cyc(6);
    clr(1'b0);
    check(o_capture_flag, 16'h0);
    cpu.wr16(2'h0, 16'h0777);
    trig(1'b0, 1'b0, 6);
    check(o_capture_flag, 16'h0);
    trig(1'b1, 1'b1, 4);
    check(o_capture_value, 16'h0777);
    clr(1'b1);
    $display("test filter and source done");
    @(posedge i_clk_sys);
    i_wave_mode_high <= 2'h3;
    cpu.wr(2'h3, 8'hab);
    cpu.wr(2'h0, 8'h01);
    cpu.wr(2'h2, 8'h02);
    cyc(0);
    check(o_count_value, 16'hab01);
    check(o_capture_value, 16'hab02);
    trig(1'b1, 1'b0, 3);
    trig(1'b1, 1'b1, 6);
    check(o_capture_flag, 16'h0);
    $display("test capture top done");
    test_done();
  end
  initial begin
    #100000;
    n_fail++;
    test_done();
  end
endmodule
bind tcc_timer_capture tcc_timer_capture_properties chk (.i_clk_sys, .i_resetn,
  .i_cpu_select, .i_cpu_read, .i_cpu_write, .i_cpu_wdata, .o_cpu_rdata,
  .i_clock_select_field, .i_wave_mode_low, .i_wave_mode_high, .i_capture_irq_enable,
  .i_capture_flag_clear, .i_capture_irq_ack, .o_count_value, .o_capture_value,
  .o_capture_flag, .o_overflow_flag, .o_capture_irq);
`default_nettype wire
